//--- core/cobid_classifier.sv
// Contract
// [R01] Identifiers are 11 bits in a standard CAN frame and select object kind.
// [R02] Bits 10..7 are the function code; bits 6..0 the node address.
// [R03] NMT is identifier 0 and SYNC is 80h, independent of node address.
// [R04] Emergency identifier defaults to code 0001 plus node address.
// [R05] First transmit PDO defaults to code 0011 plus node address.
// [R06] First receive PDO defaults to code 0100 plus node address.
// [R07] Second transmit PDO defaults to code 0101 plus node address.
// [R08] Second receive PDO defaults to code 0110 plus node address.
// [R09] Codes 0111..1010 are recognised as PDO pairs three and four.
// [R10] SDO responses default to code 1011 plus node address.
// [R11] SDO requests to this node use code 1100 plus node address.
// [R12] Guarding and heartbeat default to code 1110 plus node address; the code always uses this identifier and has no configuration slot for it.
// [R13] Exactly two receive and two transmit PDOs are provided.
// [R14] Non-fixed identifiers are replaceable in configuration; decoding uses them.
// [R15] SDO requests name index and sub-index; node serves and answers.
// [R16] PDOs carry mapped data only and outrank SDOs on the bus.
// [R17] Node can send an emergency message on internal error.
// [R18] Node consumes SYNC and may send periodic data on each one.
// [R19] Node executes NMT commands and sends error-control messages when enabled.
// [R20] Stopped handles only NMT; pre-operational handles all except PDOs. The code still sends error-control messages while stopped.
// [R21] SDO dictionary objects use a 16-bit index.
// [R22] Frames not matching an enabled object for this node change nothing.
`timescale 1ns/100ps
module cobid_classifier
	import cobid_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic [6:0]  nodeAddr,
	input  wire logic        rxValid,
	input  wire logic [10:0] rxId,
	input  wire logic        rxExtended,
	input  wire logic [7:0]  rxByte0,
	input  wire logic [7:0]  rxByte1,
	input  wire logic [7:0]  rxByte2,
	input  wire logic [7:0]  rxByte3,
	input  wire logic        cfgWrite,
	input  wire logic [2:0]  cfgSel,
	input  wire logic [10:0] cfgId,
	input  wire logic        errEvent,
	input  wire logic        errCtrlEnable,
	input  wire logic        errCtrlTick,
	output logic [3:0]       msgClass,
	output logic [3:0]       funcCode,
	output logic [6:0]       srcAddr,
	output logic             msgValid,
	output logic [1:0]       nodeState,
	output logic             syncPulse,
	output logic             resetNodeReq,
	output logic             resetCommReq,
	output logic [15:0]      sdoIndex,
	output logic [7:0]       sdoSubIndex,
	output logic             sdoReq,
	output logic [10:0]      txEmcyId,
	output logic             txEmcyReq,
	output logic [10:0]      txPdo1Id,
	output logic [10:0]      txPdo2Id,
	output logic             txPdoReq,
	output logic [10:0]      txSdoId,
	output logic [10:0]      txErrCtrlId,
	output logic             txErrCtrlReq
);

	// ==========================================================
	// Configurable identifiers
	logic [10:0]  cfgEmcy, cfgTpdo1, cfgTpdo2, cfgRpdo1, cfgRpdo2, cfgSdoRx, cfgSdoTx;
	logic [6:0]   nodeAddrLatched;
	logic [6:0]   nodeAddrMeta;
	logic [6:0]   nodeAddrSync;
	cobid_state_t state;

	// Address switches pass two flip-flops before use
	always_ff @(posedge clk) begin
		nodeAddrMeta <= nodeAddr;
		nodeAddrSync <= nodeAddrMeta;
	end

	wire logic [10:0] defEmcy  = {FC_EMCY, nodeAddrSync};  // R04
	wire logic [10:0] defTpdo1 = {FC_TPD1, nodeAddrSync};  // R05
	wire logic [10:0] defRpdo1 = {FC_RPD1, nodeAddrSync};  // R06
	wire logic [10:0] defTpdo2 = {FC_TPD2, nodeAddrSync};  // R07
	wire logic [10:0] defRpdo2 = {FC_RPD2, nodeAddrSync};  // R08
	wire logic [10:0] defSdoTx = {FC_SDOTX, nodeAddrSync}; // R10
	wire logic [10:0] defSdoRx = {FC_SDORX, nodeAddrSync}; // R11

	// ==========================================================
	// Decode
	wire logic [3:0] rxFc   = rxId[FC_HI:FC_LO];   // R02
	wire logic [6:0] rxAddr = rxId[ADDR_W-1:0];    // R02
	wire logic       frameOk = rxValid && !rxExtended; // R01
	wire logic       pdoOk   = (state == COBID_OPER);  // R20
	wire logic       objOk   = (state == COBID_OPER) || (state == COBID_PREOP); // R20
	wire logic       hitNmt  = frameOk && (rxId == ID_NMT); // R03
	wire logic       hitSync = frameOk && objOk && (rxId == ID_SYNC); // R03 R18
	wire logic       hitRp1  = frameOk && pdoOk && (rxId == cfgRpdo1); // R13 R14
	wire logic       hitRp2  = frameOk && pdoOk && (rxId == cfgRpdo2); // R13 R14
	wire logic       hitSdo  = frameOk && objOk && (rxId == cfgSdoRx); // R11 R14
	wire logic       hitPdoX = frameOk && pdoOk && (rxFc >= FC_PD3LO) && (rxFc <= FC_PD4HI)
	                           && (rxAddr == nodeAddrLatched); // R09
	wire logic       nmtForMe = hitNmt && ((rxByte1 == {1'b0, nodeAddrLatched}) || (rxByte1 == 8'h00));
	wire logic       anyHit  = nmtForMe || hitSync || hitRp1 || hitRp2 || hitSdo || hitPdoX; // R22
	wire logic [3:0] next_msgClass = nmtForMe ? COBID_NMT :
	                                 hitSync  ? COBID_SYNC :
	                                 hitRp1   ? COBID_RPDO1 :
	                                 hitRp2   ? COBID_RPDO2 :
	                                 hitSdo   ? COBID_SDORQ :
	                                 hitPdoX  ? COBID_PDOX : COBID_NONE;

	// ==========================================================
	// NMT state machine
	logic         started;
	cobid_state_t next_state;
	wire logic    nmtStart = nmtForMe && (rxByte0 == NMT_START);
	wire logic    nmtStop  = nmtForMe && (rxByte0 == NMT_STOP);
	wire logic    nmtPreop = nmtForMe && (rxByte0 == NMT_PREOP);
	wire logic    nmtRst   = nmtForMe && ((rxByte0 == NMT_RNODE) || (rxByte0 == NMT_RCOMM));

	always_comb begin
		next_state = state;
		unique case (state)
			COBID_INIT:  next_state = COBID_PREOP;
			COBID_STOP,
			COBID_PREOP,
			COBID_OPER: begin
				if (nmtRst)        next_state = COBID_INIT;   // R19
				else if (nmtStart) next_state = COBID_OPER;   // R19
				else if (nmtStop)  next_state = COBID_STOP;   // R19
				else if (nmtPreop) next_state = COBID_PREOP;  // R19
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			state <= COBID_INIT;
			started <= 1'b0;
		end else begin
			state <= next_state;
			started <= 1'b1;
		end
	end

	// Address and default identifiers taken while in initialisation, on the step to pre-operational
	wire logic loadDefaults = (state == COBID_INIT);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			nodeAddrLatched <= 7'h00;
			cfgEmcy  <= 11'h000;
			cfgTpdo1 <= 11'h000;
			cfgTpdo2 <= 11'h000;
			cfgRpdo1 <= 11'h000;
			cfgRpdo2 <= 11'h000;
			cfgSdoRx <= 11'h000;
			cfgSdoTx <= 11'h000;
		end else if (loadDefaults) begin
			nodeAddrLatched <= nodeAddrSync;
			cfgEmcy  <= defEmcy;
			cfgTpdo1 <= defTpdo1;
			cfgTpdo2 <= defTpdo2;
			cfgRpdo1 <= defRpdo1;
			cfgRpdo2 <= defRpdo2;
			cfgSdoRx <= defSdoRx;
			cfgSdoTx <= defSdoTx;
		end else if (cfgWrite && (state == COBID_PREOP)) begin // R14
			unique case (cfgSel)
				3'h0: cfgEmcy  <= cfgId;
				3'h1: cfgTpdo1 <= cfgId;
				3'h2: cfgTpdo2 <= cfgId;
				3'h3: cfgRpdo1 <= cfgId;
				3'h4: cfgRpdo2 <= cfgId;
				3'h5: cfgSdoRx <= cfgId;
				3'h6: cfgSdoTx <= cfgId;
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Classification outputs
	wire logic sdoHit = hitSdo;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			msgClass <= COBID_NONE;
			funcCode <= 4'h0;
			srcAddr <= 7'h00;
			msgValid <= 1'b0;
			syncPulse <= 1'b0;
			resetNodeReq <= 1'b0;
			resetCommReq <= 1'b0;
			sdoReq <= 1'b0;
			sdoIndex <= 16'h0000;
			sdoSubIndex <= 8'h00;
			txPdoReq <= 1'b0;
		end else begin
			msgValid <= anyHit; // R22
			syncPulse <= hitSync; // R18
			txPdoReq <= hitSync && pdoOk; // R18 R16
			resetNodeReq <= nmtForMe && (rxByte0 == NMT_RNODE); // R19
			resetCommReq <= nmtForMe && (rxByte0 == NMT_RCOMM); // R19
			sdoReq <= sdoHit; // R15
			if (anyHit) begin // R22
				msgClass <= next_msgClass;
				funcCode <= rxFc;
				srcAddr <= rxAddr;
			end
			if (sdoHit) begin
				sdoIndex <= {rxByte2, rxByte1}; // R15 R21
				sdoSubIndex <= rxByte3; // R15
			end
		end
	end

	// ==========================================================
	// Transmit requests
	always_ff @(posedge clk) begin
		if (!rstn) begin
			txEmcyReq <= 1'b0;
			txErrCtrlReq <= 1'b0;
			txEmcyId <= 11'h000;
			txPdo1Id <= 11'h000;
			txPdo2Id <= 11'h000;
			txSdoId <= 11'h000;
			txErrCtrlId <= 11'h000;
			nodeState <= 2'b00;
		end else begin
			txEmcyReq <= errEvent && objOk; // R17
			txErrCtrlReq <= errCtrlEnable && errCtrlTick && started && (state != COBID_INIT); // R19
			txEmcyId <= cfgEmcy; // R04 R14
			txPdo1Id <= cfgTpdo1; // R05 R13
			txPdo2Id <= cfgTpdo2; // R07 R13
			txSdoId <= cfgSdoTx; // R10
			txErrCtrlId <= {FC_ERRC, nodeAddrLatched}; // R12
			nodeState <= state;
		end
	end

	// ==========================================================
	// Assertions
	a_stop_no_sync: assert property (@(posedge clk) disable iff (!rstn) // R20
		(state == COBID_STOP) |=> !syncPulse && !sdoReq && !txPdoReq)
		else $error("Stopped node handled a non-NMT object");
	a_preop_no_pdo: assert property (@(posedge clk) disable iff (!rstn) // R20
		(state != COBID_OPER) |=> !txPdoReq)
		else $error("PDO activity outside operational");
	a_sync_fixed_id: assert property (@(posedge clk) disable iff (!rstn) // R03
		syncPulse |-> $past(rxId) == ID_SYNC)
		else $error("SYNC pulse without identifier 80h");
	a_nmt_start_op: assert property (@(posedge clk) disable iff (!rstn) // R19
		(nmtStart && !nmtRst && state != COBID_INIT) |=> ##1 nodeState == COBID_OPER)
		else $error("Start command did not reach operational");
	a_ignore_foreign: assert property (@(posedge clk) disable iff (!rstn) // R22
		!anyHit |=> $stable(msgClass) && !msgValid)
		else $error("Unmatched frame changed state");
	a_err_ctrl_id: assert property (@(posedge clk) disable iff (!rstn) // R12
		txErrCtrlReq |-> txErrCtrlId[10:7] == FC_ERRC)
		else $error("Error-control identifier wrong code");
	a_sdo_index: assert property (@(posedge clk) disable iff (!rstn) // R21
		sdoReq |-> sdoIndex == {$past(rxByte2), $past(rxByte1)})
		else $error("SDO index not captured");
	a_func_split: assert property (@(posedge clk) disable iff (!rstn) // R02
		msgValid |-> {funcCode, srcAddr} == $past(rxId))
		else $error("Function code split wrong");
	a_rpdo_match: assert property (@(posedge clk) disable iff (!rstn) // R14
		msgValid && (msgClass == COBID_RPDO1) |-> $past(rxId) == $past(cfgRpdo1))
		else $error("RPDO1 matched wrong identifier");
	a_emcy_gate: assert property (@(posedge clk) disable iff (!rstn) // R17
		txEmcyReq |-> $past(errEvent))
		else $error("Emergency request without error");
	a_ext_ignored: assert property (@(posedge clk) disable iff (!rstn) // R01
		(rxValid && rxExtended) |=> !msgValid)
		else $error("Extended frame was classified");
	a_nmt_fixed_id: assert property (@(posedge clk) disable iff (!rstn) // R03
		(msgValid && (msgClass == COBID_NMT)) |-> $past(rxId) == ID_NMT)
		else $error("NMT class without identifier 0");
	a_emcy_default: assert property (@(posedge clk) disable iff (!rstn) // R04 R05
		loadDefaults |=> ##1 (txEmcyId == {FC_EMCY, nodeAddrLatched})
			&& (txPdo1Id == {FC_TPD1, nodeAddrLatched}))
		else $error("Emergency or first transmit default wrong");
	a_tpdo2_default: assert property (@(posedge clk) disable iff (!rstn) // R07 R10
		loadDefaults |=> ##1 (txPdo2Id == {FC_TPD2, nodeAddrLatched})
			&& (txSdoId == {FC_SDOTX, nodeAddrLatched}))
		else $error("Second transmit or SDO response default wrong");
	a_rpdo_default: assert property (@(posedge clk) disable iff (!rstn) // R06 R08
		loadDefaults |=> (cfgRpdo1 == {FC_RPD1, nodeAddrLatched})
			&& (cfgRpdo2 == {FC_RPD2, nodeAddrLatched}))
		else $error("Receive PDO default wrong");
	a_pdo_prio: assert property (@(posedge clk) disable iff (!rstn) // R16
		loadDefaults |=> (cfgTpdo1 < cfgSdoTx) && (cfgRpdo2 < cfgSdoRx))
		else $error("PDO default does not outrank SDO");
	a_rpdo2_match: assert property (@(posedge clk) disable iff (!rstn) // R14
		(msgValid && (msgClass == COBID_RPDO2)) |-> $past(rxId) == $past(cfgRpdo2))
		else $error("RPDO2 matched wrong identifier");
	a_sdo_match: assert property (@(posedge clk) disable iff (!rstn) // R11 R14
		sdoReq |-> $past(rxId) == $past(cfgSdoRx))
		else $error("SDO request matched wrong identifier");
	a_pdox_range: assert property (@(posedge clk) disable iff (!rstn) // R09
		(msgValid && (msgClass == COBID_PDOX))
			|-> ($past(rxId[10:7]) >= FC_PD3LO) && ($past(rxId[10:7]) <= FC_PD4HI))
		else $error("Extra PDO class outside code range");
	a_pdox_addr: assert property (@(posedge clk) disable iff (!rstn) // R22
		(msgValid && (msgClass == COBID_PDOX)) |-> $past(rxId[6:0]) == $past(nodeAddrLatched))
		else $error("Extra PDO for another node accepted");
	a_pdo_oper: assert property (@(posedge clk) disable iff (!rstn) // R20
		(msgValid && ((msgClass == COBID_RPDO1) || (msgClass == COBID_RPDO2) || (msgClass == COBID_PDOX)))
			|-> $past(state) == COBID_OPER)
		else $error("PDO accepted outside operational");
	a_stop_nmt_only: assert property (@(posedge clk) disable iff (!rstn) // R20
		(state == COBID_STOP) |=> !msgValid || (msgClass == COBID_NMT))
		else $error("Stopped node accepted a non-NMT frame");
	a_sync_pdo: assert property (@(posedge clk) disable iff (!rstn) // R18
		(hitSync && pdoOk) |=> txPdoReq && syncPulse)
		else $error("SYNC in operational gave no PDO request");
	a_pdo_on_sync: assert property (@(posedge clk) disable iff (!rstn) // R16 R18
		txPdoReq |-> syncPulse)
		else $error("PDO request without SYNC");
	a_emcy_raise: assert property (@(posedge clk) disable iff (!rstn) // R17
		(errEvent && objOk) |=> txEmcyReq)
		else $error("Internal error gave no emergency request");
	a_emcy_stopped: assert property (@(posedge clk) disable iff (!rstn) // R20
		(state == COBID_STOP) |=> !txEmcyReq)
		else $error("Emergency request while stopped");
	a_errc_cause: assert property (@(posedge clk) disable iff (!rstn) // R19
		txErrCtrlReq |-> $past(errCtrlEnable) && $past(errCtrlTick))
		else $error("Error-control request without enabled tick");
	a_errc_raise: assert property (@(posedge clk) disable iff (!rstn) // R19
		(errCtrlEnable && errCtrlTick && (state != COBID_INIT)) |=> txErrCtrlReq)
		else $error("Enabled tick gave no error-control request");
	a_nmt_stop_state: assert property (@(posedge clk) disable iff (!rstn) // R19
		(nmtStop && (state != COBID_INIT)) |=> ##1 nodeState == COBID_STOP)
		else $error("Stop command did not reach stopped");
	a_nmt_preop_state: assert property (@(posedge clk) disable iff (!rstn) // R19
		(nmtPreop && (state != COBID_INIT)) |=> ##1 nodeState == COBID_PREOP)
		else $error("Pre-operational command not obeyed");
	a_nmt_reset_state: assert property (@(posedge clk) disable iff (!rstn) // R19
		(nmtRst && (state != COBID_INIT)) |=> ##1 nodeState == COBID_INIT)
		else $error("Reset command did not reach initialisation");
	a_reset_req: assert property (@(posedge clk) disable iff (!rstn) // R19
		(resetNodeReq || resetCommReq) |-> msgValid && (msgClass == COBID_NMT))
		else $error("Reset request without NMT frame");
	a_sdo_subindex: assert property (@(posedge clk) disable iff (!rstn) // R15
		sdoReq |-> sdoSubIndex == $past(rxByte3))
		else $error("SDO sub-index not captured");
	a_state_hold: assert property (@(posedge clk) disable iff (!rstn) // R22
		(!nmtForMe && (state != COBID_INIT)) |=> $stable(state))
		else $error("State changed without NMT command");
	a_cfg_locked: assert property (@(posedge clk) disable iff (!rstn) // R14
		((state == COBID_STOP) || (state == COBID_OPER))
			|=> $stable(cfgTpdo1) && $stable(cfgRpdo1) && $stable(cfgSdoRx))
		else $error("Identifier changed outside configuration");
	a_cfg_write: assert property (@(posedge clk) disable iff (!rstn) // R14
		(cfgWrite && (state == COBID_PREOP) && (cfgSel == 3'h3)) |=> cfgRpdo1 == $past(cfgId))
		else $error("Configured identifier not stored");

endmodule

//--- shared/cobid_pkg.sv
package cobid_pkg;

	// ==========================================================
	// Identifier layout
	localparam int ID_W       = 11;
	localparam int FC_HI      = 10;
	localparam int FC_LO      = 7;
	localparam int ADDR_W     = 7;
	localparam int IDX_W      = 16;
	localparam int SUB_W      = 8;

	// ==========================================================
	// Function codes
	localparam logic [3:0] FC_NMT   = 4'h0;
	localparam logic [3:0] FC_EMCY  = 4'h1;
	localparam logic [3:0] FC_TPD1  = 4'h3;
	localparam logic [3:0] FC_RPD1  = 4'h4;
	localparam logic [3:0] FC_TPD2  = 4'h5;
	localparam logic [3:0] FC_RPD2  = 4'h6;
	localparam logic [3:0] FC_PD3LO = 4'h7;
	localparam logic [3:0] FC_PD4HI = 4'ha;
	localparam logic [3:0] FC_SDOTX = 4'hb;
	localparam logic [3:0] FC_SDORX = 4'hc;
	localparam logic [3:0] FC_ERRC  = 4'he;

	// ==========================================================
	// Fixed identifiers
	localparam logic [10:0] ID_NMT  = 11'h000;
	localparam logic [10:0] ID_SYNC = 11'h080;

	// ==========================================================
	// NMT command specifiers
	localparam logic [7:0] NMT_START = 8'h01;
	localparam logic [7:0] NMT_STOP  = 8'h02;
	localparam logic [7:0] NMT_PREOP = 8'h80;
	localparam logic [7:0] NMT_RNODE = 8'h81;
	localparam logic [7:0] NMT_RCOMM = 8'h82;

	// ==========================================================
	// Message classes
	typedef enum logic [3:0] {
		COBID_NONE  = 4'h0,
		COBID_NMT   = 4'h1,
		COBID_SYNC  = 4'h2,
		COBID_RPDO1 = 4'h3,
		COBID_RPDO2 = 4'h4,
		COBID_SDORQ = 4'h5,
		COBID_PDOX  = 4'h6,
		COBID_OTHER = 4'h7
	} cobid_class_t;

	// Node states
	typedef enum logic [1:0] {
		COBID_INIT  = 2'b00,
		COBID_STOP  = 2'b01,
		COBID_PREOP = 2'b10,
		COBID_OPER  = 2'b11
	} cobid_state_t;

endpackage

//--- verif/cob_id_message_classifier_bench.sv
`timescale 1ns/100ps
module cob_id_message_classifier_bench
	import cobid_pkg::*;
();
	localparam logic [6:0] NODE = 7'h2a;
	logic        clk, rstn, rxValid, rxExtended, cfgWrite, errEvent, errCtrlEnable, errCtrlTick;
	logic        msgValid, syncPulse, resetNodeReq, resetCommReq, sdoReq, txEmcyReq, txPdoReq, txErrCtrlReq;
	logic [1:0]  nodeState;
	logic [2:0]  cfgSel;
	logic [3:0]  msgClass, funcCode;
	logic [6:0]  nodeAddr, srcAddr;
	logic [7:0]  rxByte0, rxByte1, rxByte2, rxByte3, sdoSubIndex;
	logic [10:0] rxId, cfgId, txEmcyId, txPdo1Id, txPdo2Id, txSdoId, txErrCtrlId;
	logic [15:0] sdoIndex;
	int          error_cnt = 0;
	int          cmp_count = 0;

	cobid_master_model master (.clk, .rxValid, .rxExtended, .rxId, .rxByte0, .rxByte1, .rxByte2, .rxByte3);
	cobid_classifier DUT (.clk, .rstn, .nodeAddr, .rxValid, .rxId, .rxExtended, .rxByte0, .rxByte1,
		.rxByte2, .rxByte3, .cfgWrite, .cfgSel, .cfgId, .errEvent, .errCtrlEnable, .errCtrlTick,
		.msgClass, .funcCode, .srcAddr, .msgValid, .nodeState, .syncPulse, .resetNodeReq, .resetCommReq,
		.sdoIndex, .sdoSubIndex, .sdoReq, .txEmcyId, .txEmcyReq, .txPdo1Id, .txPdo2Id, .txPdoReq,
		.txSdoId, .txErrCtrlId, .txErrCtrlReq);

	// ========================================
	// Helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic hit(input logic [10:0] id, input logic [31:0] data, input logic [3:0] cls);
		master.send(id, 1'b0, data);
		chk(msgValid, cls != 4'h0);
		if (cls != 4'h0) chk(msgClass, cls);
	endtask
	task automatic sig(input logic e, input logic t);
		tick(1);
		{errEvent, errCtrlTick} = {e, t};
		tick(1);
		{errEvent, errCtrlTick} = 2'b00;
	endtask
	task automatic cfg(input logic [2:0] sel, input logic [10:0] id);
		{cfgSel, cfgId, cfgWrite} = {sel, id, 1'b1};
		tick(1);
		cfgWrite = 1'b0;
		tick(1);
	endtask
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ========================================
	// Scenarios
	task automatic t_defaults();
		chk(nodeState, COBID_PREOP);
		chk(txEmcyId, {FC_EMCY, NODE});
		chk(txPdo1Id, {FC_TPD1, NODE});
		chk(txPdo2Id, {FC_TPD2, NODE});
		chk(txSdoId, {FC_SDOTX, NODE});
		chk(txErrCtrlId, {FC_ERRC, NODE});
	endtask
	task automatic t_preop();
		hit(ID_SYNC, 32'h0, COBID_SYNC);
		chk(syncPulse, 1'b1);
		chk(txPdoReq, 1'b0);
		hit({FC_SDORX, NODE}, 32'h40181002, COBID_SDORQ);
		chk(sdoReq, 1'b1);
		chk(sdoIndex, 16'h1018);
		chk(sdoSubIndex, 8'h02);
		chk(funcCode, FC_SDORX);
		chk(srcAddr, NODE);
		hit({FC_RPD1, NODE}, 32'h0, 4'h0);
		master.send({FC_SDORX, NODE}, 1'b1, 32'h0);
		chk(msgValid, 1'b0);
	endtask
	task automatic t_oper();
		hit(ID_NMT, {NMT_START, 1'b0, NODE, 16'h0}, COBID_NMT);
		tick(1);
		chk(nodeState, COBID_OPER);
		hit({FC_RPD1, NODE}, 32'h1, COBID_RPDO1);
		hit({FC_RPD2, NODE}, 32'h2, COBID_RPDO2);
		hit({FC_PD3LO, NODE}, 32'h3, COBID_PDOX);
		hit({FC_PD4HI, NODE}, 32'h4, COBID_PDOX);
		hit({FC_RPD1, NODE ^ 7'h01}, 32'h5, 4'h0);
		chk(msgClass, COBID_PDOX);
		hit(ID_SYNC, 32'h0, COBID_SYNC);
		chk(txPdoReq, 1'b1);
		hit(ID_NMT, {NMT_STOP, 24'h0}, COBID_NMT);
		tick(1);
		chk(nodeState, COBID_STOP);
		hit(ID_SYNC, 32'h0, 4'h0);
		hit({FC_SDORX, NODE}, 32'h0, 4'h0);
	endtask
	task automatic t_errors();
		errCtrlEnable = 1'b1;
		sig(1'b1, 1'b1);
		chk(txEmcyReq, 1'b0);
		chk(txErrCtrlReq, 1'b1);
		errCtrlEnable = 1'b0;
		sig(1'b0, 1'b1);
		chk(txErrCtrlReq, 1'b0);
		hit(ID_NMT, {NMT_PREOP, 24'h0}, COBID_NMT);
		sig(1'b1, 1'b0);
		chk(txEmcyReq, 1'b1);
	endtask
	task automatic t_cfg();
		cfg(3'h0, 11'h0c1);
		chk(txEmcyId, 11'h0c1);
		cfg(3'h3, 11'h345);
		cfg(3'h4, 11'h346);
		cfg(3'h5, 11'h640);
		cfg(3'h2, 11'h2c0);
		chk(txPdo2Id, 11'h2c0);
		cfg(3'h6, 11'h5c0);
		chk(txSdoId, 11'h5c0);
		cfg(3'h7, 11'h111);
		chk(txEmcyId, 11'h0c1);
		hit(11'h640, 32'h40002001, COBID_SDORQ);
		chk(sdoIndex, 16'h2000);
		chk(sdoSubIndex, 8'h01);
		hit({FC_SDORX, NODE}, 32'h0, 4'h0);
		hit(ID_NMT, {NMT_START, 1'b0, NODE, 16'h0}, COBID_NMT);
		cfg(3'h1, 11'h1c0);
		chk(txPdo1Id, {FC_TPD1, NODE});
		hit(11'h345, 32'h0, COBID_RPDO1);
		hit(11'h346, 32'h0, COBID_RPDO2);
		hit({FC_RPD1, NODE}, 32'h0, 4'h0);
		hit(ID_NMT, {NMT_STOP, 1'b0, NODE ^ 7'h01, 16'h0}, 4'h0);
		tick(1);
		chk(nodeState, COBID_OPER);
		hit(ID_NMT, {NMT_RNODE, 1'b0, NODE, 16'h0}, COBID_NMT);
		chk(resetNodeReq, 1'b1);
		chk(resetCommReq, 1'b0);
		tick(3);
		chk(nodeState, COBID_PREOP);
		chk(txEmcyId, {FC_EMCY, NODE});
		hit(ID_NMT, {NMT_RCOMM, 24'h0}, COBID_NMT);
		chk(resetCommReq, 1'b1);
		chk(resetNodeReq, 1'b0);
	endtask

	// ========================================
	// Clock, watchdog and main sequence
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		#(20 * 2000);
		error_cnt++;
		end_sim();
	end
	initial begin
		rstn = 1'b0;
		nodeAddr = NODE;
		{cfgWrite, errEvent, errCtrlEnable, errCtrlTick, cfgSel, cfgId} = 18'h0;
		tick(8);
		rstn = 1'b1;
		tick(3);
		t_defaults();
		t_preop();
		t_oper();
		t_errors();
		t_cfg();
		end_sim();
	end
endmodule

//--- verif/cobid_master_model.sv
`timescale 1ns/100ps
// ========================================
// Network master model that drives received frames
module cobid_master_model (
	input  wire logic clk,
	output logic      rxValid,
	output logic      rxExtended,
	output logic [10:0] rxId,
	output logic [7:0]  rxByte0,
	output logic [7:0]  rxByte1,
	output logic [7:0]  rxByte2,
	output logic [7:0]  rxByte3
);
	initial begin
		{rxValid, rxExtended} = 2'b00;
		rxId = 11'h7ff;
		{rxByte0, rxByte1, rxByte2, rxByte3} = 32'h0;
	end

	// One frame, held for one edge, then lines scrambled
	task automatic send(input logic [10:0] id, input logic ext, input logic [31:0] data);
		@(posedge clk);
		#1;
		rxId = id;
		rxExtended = ext;
		{rxByte0, rxByte1, rxByte2, rxByte3} = data;
		rxValid = 1'b1;
		@(posedge clk);
		#1;
		rxValid = 1'b0;
		rxId = ~id;
		rxExtended = ~ext;
		{rxByte0, rxByte1, rxByte2, rxByte3} = ~data;
	endtask
endmodule
